// ===== rtl/lmr_top.v
// Function
// [R01] Loop voltage sign in bit six
// [R02] Loop voltage magnitude six bits, 1.5 V
// [R03] Loop current direction in bit six
// [R04] Loop current magnitude six bits, 1.25 mA
// [R05] Tip voltage eight-bit code, 0.376 V step
// [R06] Ring voltage same scaling as tip
// [R07] Two separate eight-bit battery readings
// [R08] Transistor one current eight-bit, 0.319 mA
// [R09] Extended flag removes extra current Q1/Q2
// [R10] Transistor two current, same scaling
// [R11] Transistors three and four eight-bit codes
// [R12] All registers read-only, reads harmless
//
// Local design decision: the Avalon-MM slave port.
`include "lmr_regs.vh"

module lmr_top (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Avalon-MM slave
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Converter results, same clock
  input wire meas_valid,
  input wire [3:0] meas_channel,
  input wire [7:0] meas_code,
  // Extended battery feature
  input wire extended_battery_feature_flag,
  input wire [7:0] extended_feature_current
);

  reg [7:0] loop_voltage_reading;
  reg [7:0] loop_current_reading;
  reg [7:0] tip_voltage_reading;
  reg [7:0] ring_voltage_reading;
  reg [7:0] battery_voltage_reading_a;
  reg [7:0] battery_voltage_reading_b;
  reg [7:0] transistor_one_current;
  reg [7:0] transistor_two_current;
  reg [7:0] transistor_three_current;
  reg [7:0] transistor_four_current;
  wire [7:0] q1_net;
  wire [7:0] q2_net;
  wire [7:0] bank_data;
  wire [7:0] reg_index;

  // Sign plus magnitude, bit seven reads zero
  function [7:0] lmr_signmag;
    input [7:0] code;
    begin
      lmr_signmag = {1'b0, code[`LMR_SIGN_BIT], code[`LMR_MAG_MSB:0]};
    end
  endfunction

  // Strobe for one channel of the result stream
  function lmr_hit;
    input valid;
    input [3:0] chan;
    input [3:0] want;
    begin
      lmr_hit = valid & (chan == want);
    end
  endfunction

  // [R09] Remove extended current
  lmr_sat_sub u_q1_adj (
    .raw_code(meas_code),
    .extra_code(extended_feature_current),
    .remove_extra(extended_battery_feature_flag),
    .net_code(q1_net)
  );

  // [R09] Same for transistor two
  lmr_sat_sub u_q2_adj (
    .raw_code(meas_code),
    .extra_code(extended_feature_current),
    .remove_extra(extended_battery_feature_flag),
    .net_code(q2_net)
  );

  // Only converter results update the bank; the bus has no write path
  always @(posedge core_clk) begin
    if (sys_rst) begin
      loop_voltage_reading <= `LMR_RST_READING;
      loop_current_reading <= `LMR_RST_READING;
      tip_voltage_reading <= `LMR_RST_READING;
      ring_voltage_reading <= `LMR_RST_READING;
      battery_voltage_reading_a <= `LMR_RST_READING;
      battery_voltage_reading_b <= `LMR_RST_READING;
      transistor_one_current <= `LMR_RST_CURRENT;
      transistor_two_current <= `LMR_RST_CURRENT;
      transistor_three_current <= `LMR_RST_CURRENT;
      transistor_four_current <= `LMR_RST_CURRENT;
    end else begin
      // [R01] [R02] Loop voltage sign, magnitude
      if (lmr_hit(meas_valid, meas_channel, `LMR_CH_LOOP_VOLT)) begin
        loop_voltage_reading <= lmr_signmag(meas_code);
      end
      // [R03] [R04] Loop current direction, magnitude
      if (lmr_hit(meas_valid, meas_channel, `LMR_CH_LOOP_CURR)) begin
        loop_current_reading <= lmr_signmag(meas_code);
      end
      // [R05] Tip code stored
      if (lmr_hit(meas_valid, meas_channel, `LMR_CH_TIP_VOLT)) begin
        tip_voltage_reading <= meas_code;
      end
      // [R06] Ring code stored
      if (lmr_hit(meas_valid, meas_channel, `LMR_CH_RING_VOLT)) begin
        ring_voltage_reading <= meas_code;
      end
      // [R07] Battery readings independent
      if (lmr_hit(meas_valid, meas_channel, `LMR_CH_BATT_A)) begin
        battery_voltage_reading_a <= meas_code;
      end
      if (lmr_hit(meas_valid, meas_channel, `LMR_CH_BATT_B)) begin
        battery_voltage_reading_b <= meas_code;
      end
      // [R08] Transistor one net current
      if (lmr_hit(meas_valid, meas_channel, `LMR_CH_Q1_CURR)) begin
        transistor_one_current <= q1_net;
      end
      // [R10] Transistor two net current
      if (lmr_hit(meas_valid, meas_channel, `LMR_CH_Q2_CURR)) begin
        transistor_two_current <= q2_net;
      end
      // [R11] Small transistor currents
      if (lmr_hit(meas_valid, meas_channel, `LMR_CH_Q3_CURR)) begin
        transistor_three_current <= meas_code;
      end
      if (lmr_hit(meas_valid, meas_channel, `LMR_CH_Q4_CURR)) begin
        transistor_four_current <= meas_code;
      end
    end
  end

  assign reg_index = avs_address[`LMR_ADDR_W-1:`LMR_IDX_LSB];

  // [R12] Read mux, no side effects
  assign bank_data =
    (reg_index == `LMR_IDX_LOOP_VOLT) ? loop_voltage_reading :
    (reg_index == `LMR_IDX_LOOP_CURR) ? loop_current_reading :
    (reg_index == `LMR_IDX_TIP_VOLT) ? tip_voltage_reading :
    (reg_index == `LMR_IDX_RING_VOLT) ? ring_voltage_reading :
    (reg_index == `LMR_IDX_BATT_A) ? battery_voltage_reading_a :
    (reg_index == `LMR_IDX_BATT_B) ? battery_voltage_reading_b :
    (reg_index == `LMR_IDX_Q1_CURR) ? transistor_one_current :
    (reg_index == `LMR_IDX_Q2_CURR) ? transistor_two_current :
    (reg_index == `LMR_IDX_Q3_CURR) ? transistor_three_current :
    (reg_index == `LMR_IDX_Q4_CURR) ? transistor_four_current :
    8'h00;

  // [R12] Writes acknowledged, data dropped
  lmr_bus_slave u_bus (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .bank_data(bank_data),
    .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata)
  );

endmodule // lmr_top

// ===== pkg/lmr_regs.vh
`ifndef LMR_REGS_VH
`define LMR_REGS_VH

// Register indices; byte address is four times the index
`define LMR_IDX_LOOP_VOLT 8'h4e
`define LMR_IDX_LOOP_CURR 8'h4f
`define LMR_IDX_TIP_VOLT 8'h50
`define LMR_IDX_RING_VOLT 8'h51
`define LMR_IDX_BATT_A 8'h52
`define LMR_IDX_BATT_B 8'h53
`define LMR_IDX_Q1_CURR 8'h54
`define LMR_IDX_Q2_CURR 8'h55
`define LMR_IDX_Q3_CURR 8'h56
`define LMR_IDX_Q4_CURR 8'h57

// Bus geometry
`define LMR_ADDR_W 10
`define LMR_DATA_W 32
`define LMR_IDX_LSB 2

// Measurement channel codes from the converter sequencer
`define LMR_CH_LOOP_VOLT 4'h0
`define LMR_CH_LOOP_CURR 4'h1
`define LMR_CH_TIP_VOLT 4'h2
`define LMR_CH_RING_VOLT 4'h3
`define LMR_CH_BATT_A 4'h4
`define LMR_CH_BATT_B 4'h5
`define LMR_CH_Q1_CURR 4'h6
`define LMR_CH_Q2_CURR 4'h7
`define LMR_CH_Q3_CURR 4'h8
`define LMR_CH_Q4_CURR 4'h9

// Sign and magnitude fields of the loop registers
`define LMR_SIGN_BIT 6
`define LMR_MAG_MSB 5
`define LMR_MAG_W 6
`define LMR_RSVD_BIT 7

// Reset values
`define LMR_RST_READING 8'h00
`define LMR_RST_CURRENT 8'h00

`endif

// ===== rtl/lmr_sat_sub.v
module lmr_sat_sub (
  // Raw transistor current
  input wire [7:0] raw_code,
  // Extra current to remove
  input wire [7:0] extra_code,
  input wire remove_extra,
  // Reported current
  output wire [7:0] net_code
);

  wire [8:0] diff;

  assign diff = {1'b0, raw_code} - {1'b0, extra_code};
  // Clamp at zero so a noisy sample never wraps to full scale
  assign net_code = !remove_extra ? raw_code : (diff[8] ? 8'h00 : diff[7:0]);

endmodule // lmr_sat_sub

// ===== rtl/lmr_bus_slave.v
module lmr_bus_slave (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Avalon-MM request side
  input wire avs_read,
  input wire avs_write,
  // Read data from the bank
  input wire [7:0] bank_data,
  // Avalon-MM answer side
  output wire avs_waitrequest,
  output reg [31:0] avs_readdata
);

  reg ack;

  // One wait cycle gives the bank mux a full cycle before data is sampled
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
      if (avs_read & ~ack) begin
        avs_readdata <= {24'h00_0000, bank_data};
      end
    end
  end

endmodule // lmr_bus_slave

// ===== tb/lmr_top_props.sv
module lmr_top_props (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Register bus
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // Converter side
  input wire meas_valid,
  input wire [3:0] meas_channel,
  input wire [7:0] meas_code,
  input wire extended_battery_feature_flag,
  input wire [7:0] extended_feature_current
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Read taken at this edge
  wire tk = avs_read && avs_waitrequest;
  wire [7:0] ix = avs_address[9:2];
  a_wait_one: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held too long");
  a_wait_idle: assert property (
    !(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");
  a_upper_zero: assert property (avs_readdata[31:8] == 24'h0)
    else $error("readdata upper bits set");
  a_loop_bit7: assert property (
    tk && (ix == 8'h4e || ix == 8'h4f) |=> !avs_readdata[7])
    else $error("loop register bit 7 set");
  a_read_stands: assert property (!tk |=> $stable(avs_readdata))
    else $error("readdata changed without read");
  a_unmapped_zero: assert property (
    tk && (ix < 8'h4e || ix > 8'h57) |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_tip_fresh: assert property (
    meas_valid && meas_channel == 4'h2 ##1 tk && ix == 8'h50 && !meas_valid
    |=> avs_readdata[7:0] == $past(meas_code, 2))
    else $error("tip reading wrong");
  // Only the non-clamped case; clamping is judged by the bench
  a_q1_net: assert property (
    meas_valid && meas_channel == 4'h6 && extended_battery_feature_flag
    && meas_code >= extended_feature_current ##1 tk && ix == 8'h54 && !meas_valid
    |=> avs_readdata[7:0] == $past(meas_code, 2) - $past(extended_feature_current, 2))
    else $error("transistor one net current wrong");
  c_q1_read: cover property (tk && ix == 8'h54);
  c_write: cover property (avs_write && avs_waitrequest);
  c_ext: cover property (meas_valid && extended_battery_feature_flag);
endmodule // lmr_top_props

// ===== tb/tb_lmr_top.sv
module tb_lmr_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'hffff_ffff;
  logic [3:0] avs_byteenable = 4'hf;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  logic meas_valid = 1'b0;
  logic [3:0] meas_channel = 4'h0;
  logic [7:0] meas_code = 8'h00;
  logic extended_battery_feature_flag = 1'b0;
  logic [7:0] extended_feature_current = 8'h00;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [31:0] d;
  always #4 core_clk = ~core_clk;
  lmr_top u_lmr_top (.core_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .meas_valid,
    .meas_channel, .meas_code, .extended_battery_feature_flag, .extended_feature_current);
  task complete_run;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task bus(input logic w, input logic [7:0] idx);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= {idx, 2'h0};
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask
  task rd(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx);
    chk("readdata", {24'h0, exp}, d);
  endtask
  task meas(input logic [3:0] ch, input logic [7:0] code);
    meas_valid <= 1'b1;
    meas_channel <= ch;
    meas_code <= code;
    @(posedge core_clk);
    meas_valid <= 1'b0;
  endtask
  task t_reset;
    for (int i = 0; i < 10; i++) rd(8'h4e + i[7:0], 8'h00);
  endtask
  task t_loop;
    meas(4'h0, 8'hff);
    rd(8'h4e, 8'h7f);
    meas(4'h0, 8'h8a);
    rd(8'h4e, 8'h0a);
    meas(4'h1, 8'hff);
    rd(8'h4f, 8'h7f);
    meas(4'h1, 8'h3f);
    rd(8'h4f, 8'h3f);
  endtask
  task t_codes;
    for (int c = 2; c < 10; c++) begin
      meas(c[3:0], {c[3:0], ~c[3:0]});
      rd(8'h4e + c[7:0], {c[3:0], ~c[3:0]});
    end
  endtask
  task t_ext;
    extended_battery_feature_flag <= 1'b1;
    extended_feature_current <= 8'h10;
    meas(4'h6, 8'h40);
    rd(8'h54, 8'h30);
    meas(4'h7, 8'h08);
    rd(8'h55, 8'h00);
    meas(4'h8, 8'h40);
    rd(8'h56, 8'h40);
    extended_battery_feature_flag <= 1'b0;
    meas(4'h6, 8'h40);
    rd(8'h54, 8'h40);
  endtask
  task t_ro;
    bus(1'b1, 8'h50);
    rd(8'h50, 8'h2d);
    rd(8'h4d, 8'h00);
    rd(8'h58, 8'h00);
    meas(4'ha, 8'h55);
    rd(8'h4e, 8'h0a);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      complete_run;
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset;
    t_loop;
    t_codes;
    t_ext;
    t_ro;
    complete_run;
  end
endmodule // tb_lmr_top
bind lmr_top lmr_top_props u_lmr_top_props (.core_clk, .sys_rst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .meas_valid,
  .meas_channel, .meas_code, .extended_battery_feature_flag, .extended_feature_current);
